//--- design/amo_top.sv
// Address-mode selection and operand byte ordering for fetch and data paths.
// Assumes a classic Wishbone master for registers, and a translation unit and
// memory per path that answer with a level ack held until the request drops.
//
// What this block does
// RQ1 - Fetches use real addressing when the fetch relocate bit is 0 and translated when it is 1.
// RQ2 - Loads and stores use real addressing when the data relocate bit is 0 and translated when 1.
// RQ3 - The fetch and data paths choose their addressing mode each on its own.
// RQ4 - In real mode the effective address goes out unchanged as the 32-bit physical address.
// RQ5 - In virtual mode each effective address is translated before the memory access.
// RQ6 - Bits are numbered from the most significant as 0, the least being 7, 15 or 31 by size.
// RQ7 - A set bit at position b weighs two to the power of the lsb position minus b.
// RQ8 - Bit order inside bytes and registers is big endian whatever the region's byte order.
// RQ9 - Operands are bytes, halfwords and words; strings and multiples run as sequences of these.
// RQ10 - An operand's address is the address of its lowest-numbered byte.
// RQ11 - Big-endian access puts the most significant byte at the lowest address.
// RQ12 - Little-endian access puts the least significant byte at the lowest address.
// RQ13 - Memory is big endian by default, with little-endian regions fully supported.
// RQ14 - Each access carries an endian attribute from translation or, in real mode, the region register.
// RQ15 - Little-endian data keeps bytes, swaps halfword bytes and reverses word bytes.
// RQ16 - Effective addresses are formed by unsigned 32-bit sums that wrap past the top.
// RQ17 - A relocate change affects the next access taken, never one already in progress.
//
// Chosen here: the Wishbone slave port and the address map.
`timescale 1ns/100ps
`default_nettype none
module amo_top (
  input wire logic CLK,               // Core clock, 40 MHz
  input wire logic RST_B,             // Asynchronous reset, active low
  input wire logic WB_CYC_I,          // Wishbone cycle
  input wire logic WB_STB_I,          // Wishbone strobe
  input wire logic WB_WE_I,           // Wishbone write enable
  input wire logic [7:0] WB_ADR_I,    // Wishbone byte address
  input wire logic [3:0] WB_SEL_I,    // Wishbone byte lanes
  input wire logic [31:0] WB_DAT_I,   // Wishbone write data
  output logic [31:0] WB_DAT_O,       // Wishbone read data
  output logic WB_ACK_O,              // Wishbone acknowledge
  input wire logic F_REQ,             // Fetch request
  input wire logic [31:0] F_EA,       // Fetch effective address
  output logic F_ACCEPT,              // Fetch request taken
  output logic F_DONE,                // Fetch finished
  output logic [31:0] F_INSTR,        // Fetched word in big-endian order
  input wire logic D_REQ,             // Data request
  input wire logic [31:0] D_BASE,     // Data address base
  input wire logic [31:0] D_OFFSET,   // Data address offset or index
  input wire logic D_WE,              // Data store
  input wire logic [1:0] D_SIZE,      // Data operand size
  input wire logic [31:0] D_WDATA,    // Store value, right-justified
  output logic D_ACCEPT,              // Data request taken
  output logic D_DONE,                // Data access finished
  output logic [31:0] D_RDATA,        // Load value, right-justified
  output logic FX_REQ,                // Fetch translation request
  output logic [31:0] FX_EA,          // Fetch address to translate
  input wire logic FX_ACK,            // Fetch translation answer
  input wire logic [31:0] FX_PA,      // Fetch translated address
  input wire logic FX_LE,             // Fetch region endian attribute
  output logic FM_REQ,                // Fetch memory request
  output logic [31:0] FM_PA,          // Fetch physical address
  output logic FM_LE,                 // Fetch endian attribute
  input wire logic FM_ACK,            // Fetch memory answer
  input wire logic [31:0] FM_RDATA,   // Fetch word in address order
  output logic DX_REQ,                // Data translation request
  output logic [31:0] DX_EA,          // Data address to translate
  input wire logic DX_ACK,            // Data translation answer
  input wire logic [31:0] DX_PA,      // Data translated address
  input wire logic DX_LE,             // Data region endian attribute
  output logic DM_REQ,                // Data memory request
  output logic [31:0] DM_PA,          // Data physical address
  output logic DM_LE,                 // Data endian attribute
  output logic DM_WE,                 // Data memory write
  output logic [1:0] DM_SIZE,         // Data memory operand size
  output logic [31:0] DM_WDATA,       // Store bytes in address order
  input wire logic DM_ACK,            // Data memory answer
  input wire logic [31:0] DM_RDATA    // Load bytes in address order
);

  logic rst_meta_r;
  logic rst_n;

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      rst_meta_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n <= rst_meta_r;
    end
  end

  logic [31:0] msr_r, msr_nxt;
  logic [31:0] storage_little_endian_reg_r, storage_little_endian_reg_nxt;
  logic [31:0] last_pa_r, last_pa_nxt;
  logic ack_r, ack_nxt;
  logic [31:0] rdat_r, rdat_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [1:0] size_r, size_nxt;
  logic we_r, we_nxt;
  logic [31:0] d_rdata_r, d_rdata_nxt;
  logic [31:0] f_instr_r, f_instr_nxt;
  logic f_le_r, f_le_nxt;
  logic d_le_r, d_le_nxt;

  logic [31:0] d_ea;
  logic f_real_le;
  logic d_real_le;
  logic f_busy;
  logic d_busy;
  logic [31:0] f_swapped;
  logic [31:0] d_load_swapped;
  logic [31:0] status;
  logic wb_req;

  // Carries out of the top bit fall away, so a sum past the top wraps round through zero.
  assign d_ea = D_BASE + D_OFFSET; // see RQ16

  // Region n is big-endian bit n of the register; index 31-n equals ~n here.
  assign f_real_le = storage_little_endian_reg_r[~F_EA[amo_pkg::REGION_MSB:amo_pkg::REGION_LSB]]; // see RQ6 RQ7 RQ14
  assign d_real_le = storage_little_endian_reg_r[~d_ea[amo_pkg::REGION_MSB:amo_pkg::REGION_LSB]]; // see RQ14

  amo_addr_path u_fetch_path (
    .clk(CLK),
    .rst_n(rst_n),
    .req(F_REQ),
    .ea(F_EA),
    .reloc(msr_r[amo_pkg::FETCH_RELOC_IDX]), // see RQ1
    .real_le(f_real_le),
    .accept(F_ACCEPT),
    .busy(f_busy),
    .done(F_DONE),
    .xl_req(FX_REQ),
    .xl_ea(FX_EA),
    .xl_ack(FX_ACK),
    .xl_pa(FX_PA),
    .xl_le(FX_LE),
    .mem_req(FM_REQ),
    .mem_pa(FM_PA),
    .mem_le(FM_LE),
    .mem_ack(FM_ACK)
  );

  // A second, separate path lets data translate while fetches do not.
  amo_addr_path u_data_path (
    .clk(CLK),
    .rst_n(rst_n),
    .req(D_REQ),
    .ea(d_ea),
    .reloc(msr_r[amo_pkg::DATA_RELOC_IDX]), // see RQ2 and RQ3
    .real_le(d_real_le),
    .accept(D_ACCEPT),
    .busy(d_busy),
    .done(D_DONE),
    .xl_req(DX_REQ),
    .xl_ea(DX_EA),
    .xl_ack(DX_ACK),
    .xl_pa(DX_PA),
    .xl_le(DX_LE),
    .mem_req(DM_REQ),
    .mem_pa(DM_PA),
    .mem_le(DM_LE),
    .mem_ack(DM_ACK)
  );

  // Instructions are always whole words; the decoder wants big-endian order.
  amo_lane_swap u_fetch_swap (
    .le(FM_LE),
    .size(amo_pkg::AMO_SZ_WORD),
    .din(FM_RDATA),
    .dout(f_swapped)
  );

  amo_lane_swap u_load_swap (
    .le(DM_LE),
    .size(size_r),
    .din(DM_RDATA),
    .dout(d_load_swapped)
  );

  // The endian attribute is known only after translation, so the store data
  // is reordered on its way out rather than when the request is taken.
  amo_lane_swap u_store_swap (
    .le(DM_LE),
    .size(size_r),
    .din(wdata_r),
    .dout(DM_WDATA)
  );

  assign status = (32'(f_busy) << amo_pkg::ST_FETCH_BUSY_IDX)
                | (32'(d_busy) << amo_pkg::ST_DATA_BUSY_IDX)
                | (32'(f_le_r) << amo_pkg::ST_FETCH_LE_IDX)
                | (32'(d_le_r) << amo_pkg::ST_DATA_LE_IDX);

  assign wb_req = WB_CYC_I && WB_STB_I && !ack_r;

  // Register port and operand latches.
  always_comb begin
    msr_nxt = msr_r;
    storage_little_endian_reg_nxt = storage_little_endian_reg_r;
    last_pa_nxt = last_pa_r;
    ack_nxt = wb_req;
    rdat_nxt = rdat_r;
    wdata_nxt = wdata_r;
    size_nxt = size_r;
    we_nxt = we_r;
    d_rdata_nxt = d_rdata_r;
    f_instr_nxt = f_instr_r;
    f_le_nxt = f_le_r;
    d_le_nxt = d_le_r;
    if (wb_req) begin
      rdat_nxt = 32'h0000_0000;
      if (WB_ADR_I == amo_pkg::REG_MACHINE_STATE) begin
        rdat_nxt = msr_r;
        if (WB_WE_I) begin
          for (int i = 0; i < 4; i++) begin
            if (WB_SEL_I[i]) begin
              msr_nxt[i*8 +: 8] = WB_DAT_I[i*8 +: 8]; // see RQ17
            end
          end
        end
      end else if (WB_ADR_I == amo_pkg::REG_STORAGE_LE) begin
        rdat_nxt = storage_little_endian_reg_r;
        if (WB_WE_I) begin
          for (int i = 0; i < 4; i++) begin
            if (WB_SEL_I[i]) begin
              storage_little_endian_reg_nxt[i*8 +: 8] = WB_DAT_I[i*8 +: 8];
            end
          end
        end
      end else if (WB_ADR_I == amo_pkg::REG_STATUS) begin
        rdat_nxt = status;
      end else if (WB_ADR_I == amo_pkg::REG_LAST_DATA_PA) begin
        rdat_nxt = last_pa_r;
      end
    end
    if (D_ACCEPT) begin
      wdata_nxt = D_WDATA;
      size_nxt = D_SIZE; // see RQ9
      we_nxt = D_WE;
    end
    if (F_DONE) begin
      f_instr_nxt = f_swapped; // see RQ8
      f_le_nxt = FM_LE;
    end
    if (D_DONE) begin
      last_pa_nxt = DM_PA; // see RQ10
      d_le_nxt = DM_LE;
      if (!we_r) begin
        d_rdata_nxt = d_load_swapped; // see RQ11 and RQ15
      end
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      msr_r <= amo_pkg::MACHINE_STATE_RESET;
      storage_little_endian_reg_r <= amo_pkg::STORAGE_LE_RESET; // see RQ13
      last_pa_r <= 32'h0000_0000;
      ack_r <= 1'b0;
      rdat_r <= 32'h0000_0000;
      wdata_r <= 32'h0000_0000;
      size_r <= amo_pkg::AMO_SZ_WORD;
      we_r <= 1'b0;
      d_rdata_r <= 32'h0000_0000;
      f_instr_r <= 32'h0000_0000;
      f_le_r <= 1'b0;
      d_le_r <= 1'b0;
    end else begin
      msr_r <= msr_nxt;
      storage_little_endian_reg_r <= storage_little_endian_reg_nxt;
      last_pa_r <= last_pa_nxt;
      ack_r <= ack_nxt;
      rdat_r <= rdat_nxt;
      wdata_r <= wdata_nxt;
      size_r <= size_nxt;
      we_r <= we_nxt;
      d_rdata_r <= d_rdata_nxt;
      f_instr_r <= f_instr_nxt;
      f_le_r <= f_le_nxt;
      d_le_r <= d_le_nxt;
    end
  end

  assign WB_ACK_O = ack_r;
  assign WB_DAT_O = rdat_r;
  assign F_INSTR = f_instr_r;
  assign D_RDATA = d_rdata_r;
  assign DM_WE = we_r;
  assign DM_SIZE = size_r;

endmodule
`default_nettype wire

//--- design/amo_pkg.sv
// Constants and types shared by the address-mode and operand-order block.
// Assumes a 32-bit core data path and a 32-bit classic Wishbone register port.
package amo_pkg;

  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int WB_ADR_W = 8;

  // Register byte addresses on the Wishbone port.
  localparam logic [7:0] REG_MACHINE_STATE = 8'h00;
  localparam logic [7:0] REG_STORAGE_LE = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_LAST_DATA_PA = 8'h0c;

  // Bit numbering counts from the most significant bit as 0.
  localparam int LSB_BYTE = 7;
  localparam int LSB_HALF = 15;
  localparam int LSB_WORD = 31;

  // Relocate fields of the machine-state register, in big-endian bit numbers.
  localparam int FETCH_RELOC_BE = 26;
  localparam int DATA_RELOC_BE = 27;
  // A bit at position b weighs 2**(lsb-b), so its vector index is lsb-b.
  localparam int FETCH_RELOC_IDX = LSB_WORD - FETCH_RELOC_BE;
  localparam int DATA_RELOC_IDX = LSB_WORD - DATA_RELOC_BE;

  // Status fields, big-endian bit numbers mapped to vector indices.
  localparam int ST_FETCH_BUSY_IDX = LSB_WORD - 31;
  localparam int ST_DATA_BUSY_IDX = LSB_WORD - 30;
  localparam int ST_FETCH_LE_IDX = LSB_WORD - 29;
  localparam int ST_DATA_LE_IDX = LSB_WORD - 28;

  // Reset state: real mode on both paths, every region big endian.
  localparam logic [31:0] MACHINE_STATE_RESET = 32'h0000_0000;
  localparam logic [31:0] STORAGE_LE_RESET = 32'h0000_0000;

  // The top five address bits pick one of 32 equal regions in real mode.
  localparam int REGION_MSB = 31;
  localparam int REGION_LSB = 27;

  typedef enum logic [1:0] {
    AMO_SZ_BYTE = 2'b00,
    AMO_SZ_HALF = 2'b01,
    AMO_SZ_WORD = 2'b10
  } amo_size_t;

  typedef enum logic [1:0] {
    PATH_IDLE = 2'b00,
    PATH_XLATE = 2'b01,
    PATH_MEM = 2'b10
  } amo_path_state_t;

endpackage

//--- design/amo_lane_swap.sv
// Byte-lane reorder between register order and memory address order.
// Assumes operands are right-justified; memory-side bytes run in address order.
`timescale 1ns/100ps
`default_nettype none
module amo_lane_swap (
  input wire logic le,           // Region is little endian
  input wire logic [1:0] size,   // Operand size code
  input wire logic [31:0] din,   // Operand before reorder
  output logic [31:0] dout       // Operand after reorder
);

  // Bits inside each byte never move; only whole bytes are exchanged.
  always_comb begin
    dout = din;
    if (le) begin
      case (size)
        amo_pkg::AMO_SZ_BYTE: begin
          dout = din; // see RQ15
        end
        amo_pkg::AMO_SZ_HALF: begin
          dout = {din[31:16], din[7:0], din[15:8]}; // see RQ15
        end
        default: begin
          dout = {din[7:0], din[15:8], din[23:16], din[31:24]}; // see RQ12
        end
      endcase
    end
  end

endmodule
`default_nettype wire

//--- design/amo_addr_path.sv
// One access path: chooses real or translated addressing and runs the access.
// Assumes the translation unit and memory each hold ack until the request drops.
`timescale 1ns/100ps
`default_nettype none
module amo_addr_path (
  input wire logic clk,            // Core clock
  input wire logic rst_n,          // Synchronised reset, active low
  input wire logic req,            // Core asks for an access
  input wire logic [31:0] ea,      // Effective address of the access
  input wire logic reloc,          // Relocate bit for this path
  input wire logic real_le,        // Endian attribute for real mode
  output logic accept,             // Request taken this cycle
  output logic busy,               // Access in progress
  output logic done,               // Memory answered this cycle
  output logic xl_req,             // Translation request
  output logic [31:0] xl_ea,       // Address to translate
  input wire logic xl_ack,         // Translation answer valid
  input wire logic [31:0] xl_pa,   // Translated physical address
  input wire logic xl_le,          // Endian attribute from translation
  output logic mem_req,            // Memory request
  output logic [31:0] mem_pa,      // Physical address
  output logic mem_le,             // Endian attribute of the access
  input wire logic mem_ack         // Memory answer valid
);

  amo_pkg::amo_path_state_t state_r, state_nxt;
  logic [31:0] ea_r, ea_nxt;
  logic [31:0] pa_r, pa_nxt;
  logic le_r, le_nxt;

  // The mode is sampled only when a request is taken, so a relocate change
  // never disturbs an access already under way.
  always_comb begin
    state_nxt = state_r;
    ea_nxt = ea_r;
    pa_nxt = pa_r;
    le_nxt = le_r;
    accept = 1'b0;
    done = 1'b0;
    case (state_r)
      amo_pkg::PATH_IDLE: begin
        if (req) begin
          accept = 1'b1; // see RQ17
          ea_nxt = ea;
          if (reloc) begin
            state_nxt = amo_pkg::PATH_XLATE; // see RQ5
          end else begin
            pa_nxt = ea; // see RQ4
            le_nxt = real_le; // see RQ14
            state_nxt = amo_pkg::PATH_MEM;
          end
        end
      end
      amo_pkg::PATH_XLATE: begin
        if (xl_ack) begin
          pa_nxt = xl_pa; // see RQ5
          le_nxt = xl_le; // see RQ14
          state_nxt = amo_pkg::PATH_MEM;
        end
      end
      amo_pkg::PATH_MEM: begin
        if (mem_ack) begin
          done = 1'b1;
          state_nxt = amo_pkg::PATH_IDLE;
        end
      end
      default: begin
        state_nxt = amo_pkg::PATH_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= amo_pkg::PATH_IDLE;
      ea_r <= 32'h0000_0000;
      pa_r <= 32'h0000_0000;
      le_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      ea_r <= ea_nxt;
      pa_r <= pa_nxt;
      le_r <= le_nxt;
    end
  end

  assign busy = (state_r != amo_pkg::PATH_IDLE);
  assign xl_req = (state_r == amo_pkg::PATH_XLATE);
  assign xl_ea = ea_r;
  assign mem_req = (state_r == amo_pkg::PATH_MEM);
  assign mem_pa = pa_r;
  assign mem_le = le_r;

endmodule
`default_nettype wire

//--- tb/amo_props.sv
// Concurrent checks on the ports of the address-mode block.
// Assumes it is bound into amo_top and that all checks stop while RST_B is low.
`timescale 1ns/100ps
`default_nettype none
module amo_props (
  input wire logic CLK, // clock
  input wire logic RST_B, // reset, active low
  input wire logic WB_CYC_I, // bus cycle
  input wire logic WB_STB_I, // bus strobe
  input wire logic WB_ACK_O, // bus ack
  input wire logic [31:0] F_EA, // fetch address
  input wire logic F_ACCEPT, // fetch taken
  input wire logic F_DONE, // fetch done
  input wire logic [31:0] F_INSTR, // fetched word
  input wire logic FX_REQ, // fetch xlate
  input wire logic FX_ACK, // fetch xlate ack
  input wire logic [31:0] FX_PA, // fetch xlate out
  input wire logic FX_LE, // fetch xlate endian
  input wire logic FM_REQ, // fetch mem
  input wire logic [31:0] FM_PA, // fetch mem address
  input wire logic FM_LE, // fetch mem endian
  input wire logic [31:0] FM_RDATA, // fetch mem data
  input wire logic [31:0] D_BASE, // data base
  input wire logic [31:0] D_OFFSET, // data offset
  input wire logic D_ACCEPT, // data taken
  input wire logic DX_REQ, // data xlate
  input wire logic [31:0] DX_EA, // data xlate in
  input wire logic DX_ACK, // data xlate ack
  input wire logic [31:0] DX_PA, // data xlate out
  input wire logic DX_LE, // data xlate endian
  input wire logic DM_REQ, // data mem
  input wire logic [31:0] DM_PA, // data mem address
  input wire logic DM_LE, // data mem endian
  input wire logic DM_ACK // data mem ack
);
  wire logic [31:0] fm_rev;
  assign fm_rev = {FM_RDATA[7:0], FM_RDATA[15:8], FM_RDATA[23:16], FM_RDATA[31:24]};
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_B);
  chk_wb_ack_next: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("bus ack not one cycle after request");
  chk_wb_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("bus ack longer than one cycle");
  chk_data_one_way: assert property ($past(D_ACCEPT) |-> DM_REQ != DX_REQ)
    else $error("data path took no single mode");
  chk_data_real_pa: assert property ($past(D_ACCEPT) && DM_REQ |->
    DM_PA == $past(D_BASE) + $past(D_OFFSET)) else $error("data real address wrong");
  chk_data_xl_ea: assert property ($past(D_ACCEPT) && DX_REQ |->
    DX_EA == $past(D_BASE) + $past(D_OFFSET)) else $error("data xlate address wrong");
  chk_data_xl_use: assert property ($past(DX_REQ && DX_ACK) |-> DM_REQ &&
    DM_PA == $past(DX_PA) && DM_LE == $past(DX_LE)) else $error("data xlate result lost");
  chk_fetch_real_pa: assert property ($past(F_ACCEPT) && FM_REQ |->
    FM_PA == $past(F_EA)) else $error("fetch real address wrong");
  chk_fetch_xl_use: assert property ($past(FX_REQ && FX_ACK) |-> FM_REQ &&
    FM_PA == $past(FX_PA) && FM_LE == $past(FX_LE)) else $error("fetch xlate result lost");
  chk_fetch_order: assert property ($past(F_DONE) |->
    F_INSTR == ($past(FM_LE) ? $past(fm_rev) : $past(FM_RDATA)))
    else $error("fetched word in wrong byte order");
  chk_data_hold: assert property (DM_REQ && !DM_ACK |=> DM_REQ && $stable(DM_PA))
    else $error("data request changed in flight");
endmodule
bind amo_top amo_props u_props (.*);
`default_nettype wire

//--- tb/amo_mem_model.sv
// Behavioural translation units and memories for the fetch and data paths.
// Assumes level requests held until ack; the bench sets the answer delay.
`timescale 1ns/100ps
`default_nettype none
module amo_resp (
  input wire logic clk, // clock
  input wire logic req, // request
  input wire logic [1:0] dly, // wait cycles
  output logic ack // answer, held until req drops
);
  logic [1:0] cnt;
  initial begin
    cnt = 2'h0;
    ack = 1'b0;
  end
  always @(posedge clk) begin
    if (!req) begin
      cnt <= 2'h0;
      ack <= 1'b0;
    end else if (cnt >= dly) begin
      ack <= 1'b1;
    end else begin
      cnt <= cnt + 2'h1;
    end
  end
endmodule
module amo_mem_model (
  input wire logic clk, // clock
  input wire logic [1:0] dly, // answer delay
  input wire logic fx_req, // fetch xlate
  input wire logic [31:0] fx_ea, // fetch address
  output logic fx_ack, // fetch xlate ack
  output logic [31:0] fx_pa, // fetch xlate out
  output logic fx_le, // fetch region endian
  input wire logic dx_req, // data xlate
  input wire logic [31:0] dx_ea, // data address
  output logic dx_ack, // data xlate ack
  output logic [31:0] dx_pa, // data xlate out
  output logic dx_le, // data region endian
  input wire logic fm_req, // fetch memory
  input wire logic [31:0] fm_pa, // fetch address
  output logic fm_ack, // fetch memory ack
  output logic [31:0] fm_rdata, // fetch word
  input wire logic dm_req, // data memory
  input wire logic [31:0] dm_pa, // data address
  output logic dm_ack, // data memory ack
  output logic [31:0] dm_rdata // data word
);
  amo_resp u_fx (.clk(clk), .req(fx_req), .dly(dly), .ack(fx_ack));
  amo_resp u_dx (.clk(clk), .req(dx_req), .dly(dly), .ack(dx_ack));
  amo_resp u_fm (.clk(clk), .req(fm_req), .dly(dly), .ack(fm_ack));
  amo_resp u_dm (.clk(clk), .req(dm_req), .dly(dly), .ack(dm_ack));
  // Outside an answer the lines carry the inverse, so a stale capture cannot match.
  assign fx_pa = (fx_ea + 32'h1000_0000) ^ {32{!fx_ack}};
  assign dx_pa = (dx_ea + 32'h1000_0000) ^ {32{!dx_ack}};
  assign fx_le = fx_ea[12] ^ !fx_ack;
  assign dx_le = dx_ea[12] ^ !dx_ack;
  assign fm_rdata = fm_pa ^ 32'h3c5a_a5c3 ^ {32{!fm_ack}};
  assign dm_rdata = dm_pa ^ 32'h3c5a_a5c3 ^ {32{!dm_ack}};
endmodule
`default_nettype wire

//--- tb/amo_top_tb.sv
// Self-checking bench for amo_top with the behavioural memory model.
// Assumes the partner model answers every request; only the watchdog ends a wait.
`timescale 1ns/100ps
`default_nettype none
module amo_top_tb;
  logic CLK = 1'b0, RST_B = 1'b0, WB_CYC_I = 1'b0, WB_STB_I = 1'b0, WB_WE_I = 1'b0;
  logic F_REQ = 1'b0, D_REQ = 1'b0, D_WE = 1'b0;
  logic [7:0] WB_ADR_I = 8'h00;
  logic [3:0] WB_SEL_I = 4'hf;
  logic [1:0] D_SIZE = 2'h0, dly = 2'h0;
  logic [31:0] WB_DAT_I = 32'h0, F_EA = 32'h0, D_BASE = 32'h0, D_OFFSET = 32'h0;
  logic [31:0] D_WDATA = 32'h0, msr_v = 32'h0, storage_little_endian_reg_v = 32'h0;
  wire logic [31:0] WB_DAT_O, F_INSTR, D_RDATA, FX_EA, FX_PA, FM_PA, FM_RDATA;
  wire logic [31:0] DX_EA, DX_PA, DM_PA, DM_WDATA, DM_RDATA;
  wire logic WB_ACK_O, F_ACCEPT, F_DONE, D_ACCEPT, D_DONE, FX_REQ, FX_ACK, FX_LE, FM_REQ;
  wire logic FM_LE, FM_ACK, DX_REQ, DX_ACK, DX_LE, DM_REQ, DM_LE, DM_WE, DM_ACK;
  wire logic [1:0] DM_SIZE;
  wire logic [4:0] hs;
  int error_cnt = 0, total_checks = 0;
  assign hs = {WB_ACK_O, F_ACCEPT, F_DONE, D_ACCEPT, D_DONE};
  amo_top dut (.*);
  amo_mem_model u_mem (.clk(CLK), .dly(dly), .fx_req(FX_REQ), .fx_ea(FX_EA), .fx_ack(FX_ACK),
    .fx_pa(FX_PA), .fx_le(FX_LE), .dx_req(DX_REQ), .dx_ea(DX_EA), .dx_ack(DX_ACK),
    .dx_pa(DX_PA), .dx_le(DX_LE), .fm_req(FM_REQ), .fm_pa(FM_PA), .fm_ack(FM_ACK),
    .fm_rdata(FM_RDATA), .dm_req(DM_REQ), .dm_pa(DM_PA), .dm_ack(DM_ACK),
    .dm_rdata(DM_RDATA));
  always #12.5 CLK = ~CLK;
  function automatic logic [31:0] rev(input logic [31:0] d);
    return {d[7:0], d[15:8], d[23:16], d[31:24]};
  endfunction
  function automatic logic [31:0] sw(input logic [31:0] d, input logic [1:0] sz, input logic le);
    if (!le || sz == 2'h0) return d;
    if (sz == 2'h1) return {d[31:16], d[7:0], d[15:8]};
    return rev(d);
  endfunction
  function automatic logic [31:0] msk(input logic [1:0] sz);
    return sz == 2'h0 ? 32'h0000_00ff : sz == 2'h1 ? 32'h0000_ffff : 32'hffff_ffff;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (e !== s) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Returns at the rising edge that samples the handshake high, so the caller
  // takes its answer and releases its request at that same edge.
  task automatic wait_hs(input int k);
    do begin
      @(posedge CLK);
    end while (hs[k] !== 1'b1);
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge CLK);
    WB_CYC_I <= 1'b1;
    WB_STB_I <= 1'b1;
    WB_WE_I <= we;
    WB_ADR_I <= a;
    WB_DAT_I <= d;
    wait_hs(4);
    q = WB_DAT_O;
    WB_CYC_I <= 1'b0;
    WB_STB_I <= 1'b0;
  endtask
  task automatic dop(input logic we, input logic [1:0] sz, input logic [31:0] b, o, wd);
    logic [31:0] ea, pa, sd;
    logic le;
    ea = b + o;
    pa = msr_v[amo_pkg::DATA_RELOC_IDX] ? ea + 32'h1000_0000 : ea;
    le = msr_v[amo_pkg::DATA_RELOC_IDX] ? ea[12] : storage_little_endian_reg_v[31 - ea[31:27]];
    @(posedge CLK);
    D_REQ <= 1'b1;
    D_WE <= we;
    D_SIZE <= sz;
    D_BASE <= b;
    D_OFFSET <= o;
    D_WDATA <= wd;
    wait_hs(1);
    D_REQ <= 1'b0;
    wait_hs(0);
    chk("data_pa", pa, DM_PA);
    chk("data_le", {31'h0, le}, {31'h0, DM_LE});
    chk("dm_we", {31'h0, we}, {31'h0, DM_WE});
    chk("dm_size", {30'h0, sz}, {30'h0, DM_SIZE});
    sd = DM_WDATA;
    @(negedge CLK);
    if (we) chk("store", sw(wd, sz, le) & msk(sz), sd & msk(sz));
    else chk("load", sw(pa ^ 32'h3c5a_a5c3, sz, le) & msk(sz), D_RDATA & msk(sz));
  endtask
  task automatic fop(input logic [31:0] ea);
    logic [31:0] pa;
    logic le;
    pa = msr_v[amo_pkg::FETCH_RELOC_IDX] ? ea + 32'h1000_0000 : ea;
    le = msr_v[amo_pkg::FETCH_RELOC_IDX] ? ea[12] : storage_little_endian_reg_v[31 - ea[31:27]];
    @(posedge CLK);
    F_REQ <= 1'b1;
    F_EA <= ea;
    wait_hs(3);
    F_REQ <= 1'b0;
    wait_hs(2);
    chk("fetch_pa", pa, FM_PA);
    @(negedge CLK);
    chk("instr", le ? rev(pa ^ 32'h3c5a_a5c3) : pa ^ 32'h3c5a_a5c3, F_INSTR);
  endtask
  task automatic modes(input logic [31:0] m, s);
    logic [31:0] q;
    msr_v = m;
    storage_little_endian_reg_v = s;
    wb(1'b1, amo_pkg::REG_MACHINE_STATE, m, q);
    wb(1'b1, amo_pkg::REG_STORAGE_LE, s, q);
    wb(1'b0, amo_pkg::REG_STORAGE_LE, 32'h0, q);
    chk("storage_little_endian_reg", s, q);
  endtask
  initial begin
    #(25 * 20000);
    error_cnt++;
    finish_test;
  end
  initial begin
    logic [31:0] q;
    void'($urandom(32'hac48));
    repeat (3) @(posedge CLK);
    RST_B <= 1'b1;
    repeat (3) @(posedge CLK);
    wb(1'b0, amo_pkg::REG_MACHINE_STATE, 32'h0, q);
    chk("msr_reset", amo_pkg::MACHINE_STATE_RESET, q);
    wb(1'b1, 8'h10, 32'hffff_ffff, q);
    wb(1'b0, 8'h10, 32'h0, q);
    chk("unmapped", 32'h0, q);
    for (int n = 0; n < 24; n++) begin
      dly = 2'($urandom);
      modes($urandom & 32'h30, $urandom);
      fork
        dop(n[0], 2'(n % 3), $urandom, $urandom, $urandom);
        fop({30'($urandom), 2'h0});
      join
    end
    // Offset sum past the top lands in region 0, which is made little endian here.
    modes(32'h0, 32'h8000_0000);
    dop(1'b0, 2'h2, 32'hffff_fff8, 32'h0000_0010, 32'h0);
    dly = 2'h3;
    fork
      dop(1'b1, 2'h1, 32'h0000_1000, 32'h4, 32'h1234_abcd);
      begin
        repeat (2) @(posedge CLK);
        wb(1'b1, amo_pkg::REG_MACHINE_STATE, 32'h30, q);
      end
    join
    msr_v = 32'h30;
    dop(1'b0, 2'h2, 32'h0000_1000, 32'h4, 32'h0);
    wb(1'b0, amo_pkg::REG_LAST_DATA_PA, 32'h0, q);
    chk("last_pa", 32'h1000_1004, q);
    wb(1'b0, amo_pkg::REG_STATUS, 32'h0, q);
    chk("status", 32'h1 << amo_pkg::ST_DATA_LE_IDX, q & 32'h0000_000b);
    finish_test;
  end
endmodule
`default_nettype wire
